// File: pmcap_pkg.sv
// package: layout, reset values and access structures of the capabilities word
package pmcap_pkg;

	// ****************************************************************
	// register placement
	// ****************************************************************
	localparam logic [7:0]  PMCAP_CFG_OFFSET = 8'ha2;
	localparam int          PMCAP_NUM_FUNC   = 2;

	// ****************************************************************
	// field positions inside the 16-bit word
	// ****************************************************************
	localparam int PMCAP_COLD_WAKE_BIT = 15;
	localparam int PMCAP_WAKE_HI_BIT   = 14;
	localparam int PMCAP_WAKE_LO_BIT   = 11;
	localparam int PMCAP_STATE_TWO_BIT = 10;
	localparam int PMCAP_STATE_ONE_BIT = 9;
	localparam int PMCAP_RESERVED_BITS_HI_BIT   = 8;
	localparam int PMCAP_RESERVED_BITS_LO_BIT   = 6;
	localparam int PMCAP_INIT_BIT      = 5;
	localparam int PMCAP_AUX_BIT       = 4;
	localparam int PMCAP_CLK_BIT       = 3;
	localparam int PMCAP_VER_HI_BIT    = 2;
	localparam int PMCAP_VER_LO_BIT    = 0;

	// ****************************************************************
	// reset and fixed values
	// ****************************************************************
	localparam logic [15:0] PMCAP_RESET_WORD = 16'hfe11;
	localparam logic [15:0] PMCAP_WRITE_MASK = 16'h8000;
	localparam logic [3:0]  PMCAP_WAKE_FIXED = 4'hf;
	localparam logic [2:0]  PMCAP_RESERVED_BITS_VAL   = 3'h0;
	localparam logic [2:0]  PMCAP_VERSION    = 3'h1;
	localparam logic        PMCAP_AUX_VAL    = 1'b1;
	localparam logic        PMCAP_CLK_VAL    = 1'b0;
	localparam logic        PMCAP_INIT_VAL   = 1'b0;

	// ****************************************************************
	// device power states
	// ****************************************************************
	localparam logic [1:0] PMCAP_D0     = 2'h0;
	localparam logic [1:0] PMCAP_D1     = 2'h1;
	localparam logic [1:0] PMCAP_D2     = 2'h2;
	localparam logic [1:0] PMCAP_D3_HOT = 2'h3;

	// ****************************************************************
	// configuration access carriers
	// ****************************************************************
	typedef struct packed {
		logic        write;
		logic        func;
		logic [5:0]  dword;
		logic [3:0]  be;
		logic [31:0] wdata;
	} pmcap_cfg_req_t;

	typedef struct packed {
		logic        hit;
		logic [31:0] rdata;
	} pmcap_cfg_rsp_t;

endpackage

// File: pmcap_word.sv
// module: one function's capabilities word with its single writable bit
`timescale 1ns/1ps

module pmcap_word
	import pmcap_pkg::*;
(
	input  logic        clock,      // bus clock
	input  logic        srst,       // synchronous reset, active high
	input  logic        wr_en,      // write strobe for the cold-wake bit
	input  logic        wr_bit,     // value written to the cold-wake bit
	output logic [15:0] word        // assembled capabilities word
);

	logic cold_wake_reg;

	// ****************************************************************
	// writable cold-state wake claim
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			cold_wake_reg <= PMCAP_RESET_WORD[PMCAP_COLD_WAKE_BIT]; // see R2
		end else if (wr_en) begin
			cold_wake_reg <= wr_bit; // see R2
		end
	end

	// ****************************************************************
	// fixed fields, never touched by writes
	// ****************************************************************
	always_comb begin
		word = 16'h0000;
		word[PMCAP_COLD_WAKE_BIT] = cold_wake_reg;
		word[PMCAP_WAKE_HI_BIT:PMCAP_WAKE_LO_BIT] = PMCAP_WAKE_FIXED; // see R4
		word[PMCAP_STATE_TWO_BIT] = 1'b1; // see R5
		word[PMCAP_STATE_ONE_BIT] = 1'b1; // see R6
		word[PMCAP_RESERVED_BITS_HI_BIT:PMCAP_RESERVED_BITS_LO_BIT] = PMCAP_RESERVED_BITS_VAL; // see R7
		word[PMCAP_INIT_BIT] = PMCAP_INIT_VAL; // see R8
		word[PMCAP_AUX_BIT] = PMCAP_AUX_VAL; // see R9
		word[PMCAP_CLK_BIT] = PMCAP_CLK_VAL; // see R10
		word[PMCAP_VER_HI_BIT:PMCAP_VER_LO_BIT] = PMCAP_VERSION; // see R11
	end

endmodule

// File: pmcap_wake_sel.sv
// module: picks the wake claim that applies to a function's power state
`timescale 1ns/1ps

module pmcap_wake_sel
	import pmcap_pkg::*;
(
	input  logic [15:0] word,       // capabilities word of the function
	input  logic [1:0]  pstate,     // current device power state
	output logic        wake_ok,    // wake may be asserted in this state
	output logic        supported   // state is advertised as supported
);

	// ****************************************************************
	// state to capability bit
	// ****************************************************************
	always_comb begin
		wake_ok   = 1'b0;
		supported = 1'b1;
		case (pstate)
			PMCAP_D0: begin
				wake_ok = word[PMCAP_WAKE_LO_BIT];
			end
			PMCAP_D1: begin
				wake_ok   = word[PMCAP_WAKE_LO_BIT + 1];
				supported = word[PMCAP_STATE_ONE_BIT]; // see R12
			end
			PMCAP_D2: begin
				wake_ok   = word[PMCAP_WAKE_LO_BIT + 2];
				supported = word[PMCAP_STATE_TWO_BIT]; // see R12
			end
			PMCAP_D3_HOT: begin
				wake_ok = word[PMCAP_WAKE_HI_BIT];
			end
			default: begin
				wake_ok   = 1'b0;
				supported = 1'b0;
			end
		endcase
	end

endmodule

// File: pmcap_top.sv
// module: capabilities word of both bridge functions behind config access
`timescale 1ns/1ps

// Functional notes
// R1: each function shows its own word at offset A2h, reset FE11h
// R2: bit 15 is writable storage, reset 1, claims wake from cold D3
// R3: firmware writes 0 to bit 15 when no auxiliary power exists
// R4: bits 14 to 11 read 1: wake from hot D3, D2, D1, D0
// R5: bit 10 reads 1: D2 state supported
// R6: bit 9 reads 1: D1 state supported
// R7: bits 8 to 6 reserved, read 000b
// R8: bit 5, device-specific initialization, reads 0
// R9: bit 4 read-only, auxiliary power need, meaningful only with bit 15
// R10: bit 3 reads 0: wake needs no bus clock
// R11: bits 2 to 0 read 001b: four-byte register set
// R12: both functions support D0, D1, D2 and D3
// R13: writes change only bit 15; read-only bits keep fixed values
module pmcap_top
	import pmcap_pkg::*;
(
	input  logic                 clock,       // bus clock, 25 MHz
	input  logic                 srst,        // synchronous reset, high
	input  logic                 cfg_req,     // access request, one cycle
	input  pmcap_cfg_req_t       cfg_cmd,     // access fields
	input  logic [1:0]           pstate_f0,   // power state, function 0
	input  logic [1:0]           pstate_f1,   // power state, function 1
	output logic                 cfg_busy,    // access in progress
	output logic                 cfg_ack,     // access done, one cycle
	output pmcap_cfg_rsp_t       cfg_rsp,     // read data and hit
	output logic [15:0]          cap_word_f0, // live word, function 0
	output logic [15:0]          cap_word_f1, // live word, function 1
	output logic [1:0]           wake_ok,     // wake legal in state
	output logic [1:0]           state_ok     // state advertised
);

	// ****************************************************************
	// access sequencer states
	// ****************************************************************
	typedef enum logic [1:0] {
		PMCAP_ST_IDLE,
		PMCAP_ST_EXEC,
		PMCAP_ST_ANSWER
	} pmcap_state_t;

	pmcap_state_t   state_reg;
	pmcap_state_t   state_next;
	pmcap_cfg_req_t req_reg;
	pmcap_cfg_rsp_t rsp_reg;
	logic           ack_reg;
	logic           busy_reg;
	logic [15:0]    word_f0_reg;
	logic [15:0]    word_f1_reg;
	logic [1:0]     wake_reg;
	logic [1:0]     sup_reg;

	logic [15:0]    word     [PMCAP_NUM_FUNC];
	logic [1:0]     pstate   [PMCAP_NUM_FUNC];
	logic [1:0]     wr_en;
	logic [1:0]     wake_now;
	logic [1:0]     sup_now;
	logic           addr_hit;
	logic [15:0]    sel_word;

	assign pstate[0] = pstate_f0;
	assign pstate[1] = pstate_f1;

	// ****************************************************************
	// address decode
	// ****************************************************************
	// the word sits in the upper half of its dword, so lanes 2 and 3
	// carry it; bit 15 of the word is dword bit 31 on lane 3
	assign addr_hit = (req_reg.dword == PMCAP_CFG_OFFSET[7:2]); // see R1
	assign sel_word = req_reg.func ? word[1] : word[0]; // see R1

	// ****************************************************************
	// per-function words and wake selection
	// ****************************************************************
	for (genvar f = 0; f < PMCAP_NUM_FUNC; f++) begin : g_func
		// only lane 3 reaches storage; lane 2 holds read-only bits
		assign wr_en[f] = (state_reg == PMCAP_ST_EXEC)
			&& req_reg.write && addr_hit
			&& (req_reg.func == 1'(f))
			&& req_reg.be[3]; // see R13

		pmcap_word u_word (
			.clock  (clock),
			.srst   (srst),
			.wr_en  (wr_en[f]),
			.wr_bit (req_reg.wdata[16 + PMCAP_COLD_WAKE_BIT]),
			.word   (word[f])
		);

		pmcap_wake_sel u_sel (
			.word      (word[f]),
			.pstate    (pstate[f]),
			.wake_ok   (wake_now[f]),
			.supported (sup_now[f])
		);
	end

	// ****************************************************************
	// sequencer
	// ****************************************************************
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PMCAP_ST_IDLE: begin
				if (cfg_req) begin
					state_next = PMCAP_ST_EXEC;
				end
			end
			PMCAP_ST_EXEC: begin
				state_next = PMCAP_ST_ANSWER;
			end
			PMCAP_ST_ANSWER: begin
				state_next = PMCAP_ST_IDLE;
			end
			default: begin
				state_next = PMCAP_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg <= PMCAP_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// requests while busy are dropped; the busy flag tells the caller
	always_ff @(posedge clock) begin
		if (srst) begin
			req_reg <= '0;
		end else if (state_reg == PMCAP_ST_IDLE && cfg_req) begin
			req_reg <= cfg_cmd;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= (state_next != PMCAP_ST_IDLE);
		end
	end

	// ****************************************************************
	// answer
	// ****************************************************************
	// reads return the word as it stands in the execute cycle; writes and misses answer zero data
	always_ff @(posedge clock) begin
		if (srst) begin
			rsp_reg <= '0;
			ack_reg <= 1'b0;
		end else if (state_reg == PMCAP_ST_EXEC) begin
			ack_reg     <= 1'b1;
			rsp_reg.hit <= addr_hit;
			if (!req_reg.write && addr_hit) begin
				rsp_reg.rdata <= {sel_word, 16'h0000}; // see R1
			end else begin
				rsp_reg.rdata <= 32'h0000_0000;
			end
		end else begin
			ack_reg <= 1'b0;
		end
	end

	// ****************************************************************
	// live status toward the power-management logic
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			word_f0_reg <= PMCAP_RESET_WORD;
			word_f1_reg <= PMCAP_RESET_WORD;
		end else begin
			word_f0_reg <= word[0];
			word_f1_reg <= word[1];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			wake_reg <= 2'h0;
			sup_reg  <= 2'h3;
		end else begin
			wake_reg <= wake_now; // see R4
			sup_reg  <= sup_now; // see R12
		end
	end

	assign cfg_busy    = busy_reg;
	assign cfg_ack     = ack_reg;
	assign cfg_rsp     = rsp_reg;
	assign cap_word_f0 = word_f0_reg;
	assign cap_word_f1 = word_f1_reg;
	assign wake_ok     = wake_reg;
	assign state_ok    = sup_reg;

endmodule

// File: pmcap_checker.sv
// checker: access timing and fixed fields of the capabilities word
`timescale 1ns/1ps

module pmcap_checker
	import pmcap_pkg::*;
(
	input logic           clock,       // bus clock
	input logic           srst,        // sync reset
	input logic           cfg_req,     // access request
	input logic           cfg_busy,    // access running
	input logic           cfg_ack,     // answer pulse
	input pmcap_cfg_rsp_t cfg_rsp,     // answer data
	input logic [15:0]    cap_word_f0, // word, function 0
	input logic [15:0]    cap_word_f1, // word, function 1
	input logic [1:0]     wake_ok,     // wake claims
	input logic [1:0]     state_ok     // state claims
);
	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	a_ack_two_later: assert property (
		cfg_req && !cfg_busy |-> ##2 cfg_ack)
		else $error("answer not two cycles after request");
	a_ack_has_cause: assert property (cfg_ack |-> $past(cfg_req, 2))
		else $error("answer without request");
	a_ack_one_cycle: assert property (cfg_ack |=> !cfg_ack)
		else $error("answer longer than one cycle");
	a_busy_on_take: assert property (
		cfg_req && !cfg_busy |=> cfg_busy)
		else $error("busy not raised");
	a_fixed_bits_f0: assert property (cap_word_f0[14:0] == 15'h7e11)
		else $error("fixed bits wrong in function 0");
	a_fixed_bits_f1: assert property (cap_word_f1[14:0] == 15'h7e11)
		else $error("fixed bits wrong in function 1");
	a_low_half_zero: assert property (
		cfg_ack && cfg_rsp.hit |-> cfg_rsp.rdata[15:0] == 16'h0000)
		else $error("low half of hit answer not zero");
	a_miss_reads_zero: assert property (
		cfg_ack && !cfg_rsp.hit |-> cfg_rsp.rdata == 32'h0000_0000)
		else $error("miss answer not zero");
	a_states_claimed: assert property (state_ok == 2'b11)
		else $error("state claim missing");
	a_wake_claimed: assert property (!$past(srst) |-> wake_ok == 2'b11)
		else $error("wake claim missing");
	a_cold_by_write: assert property (
		$changed({cap_word_f1[15], cap_word_f0[15]}) |-> $past(cfg_ack))
		else $error("cold wake bit changed without access");
endmodule

bind pmcap_top pmcap_checker u_chk (.clock(clock), .srst(srst),
	.cfg_req(cfg_req), .cfg_busy(cfg_busy), .cfg_ack(cfg_ack),
	.cfg_rsp(cfg_rsp), .cap_word_f0(cap_word_f0),
	.cap_word_f1(cap_word_f1), .wake_ok(wake_ok), .state_ok(state_ok));

// File: tb_top.sv
// testbench: config accesses to the capabilities word of both functions
`timescale 1ns/1ps

module tb_top
	import pmcap_pkg::*;
;
	logic           clock = 1'b0;
	logic           srst = 1'b1;
	logic           cfg_req = 1'b0;
	pmcap_cfg_req_t cfg_cmd = '0;
	logic [1:0]     pstate_f0 = 2'h0;
	logic [1:0]     pstate_f1 = 2'h0;
	logic           cfg_busy, cfg_ack;
	pmcap_cfg_rsp_t cfg_rsp;
	logic [15:0]    cap_word_f0, cap_word_f1;
	logic [1:0]     wake_ok, state_ok;
	int             err_total = 0;
	int             checks = 0;
	logic [3:0]     bes [4] = '{4'hf, 4'h7, 4'h8, 4'hf};
	logic [31:0]    wds [4] = '{32'hffff_ffff, 32'h0000_0000,
		32'h7fff_ffff, 32'h8000_0000};
	logic [15:0]    exw [4] = '{16'hfe11, 16'hfe11, 16'h7e11, 16'hfe11};

	pmcap_top DUT (.clock(clock), .srst(srst), .cfg_req(cfg_req),
		.cfg_cmd(cfg_cmd), .pstate_f0(pstate_f0), .pstate_f1(pstate_f1),
		.cfg_busy(cfg_busy), .cfg_ack(cfg_ack), .cfg_rsp(cfg_rsp),
		.cap_word_f0(cap_word_f0), .cap_word_f1(cap_word_f1),
		.wake_ok(wake_ok), .state_ok(state_ok));

	always #20 clock = ~clock;

	// ****************************************************************
	// tasks
	// ****************************************************************
	task chk(input string nm, input logic [32:0] ex, input logic [32:0] got);
		checks++;
		if (got !== ex) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// idle gap first so no request lands while busy
	task acc(input logic wr, input logic fn, input logic [5:0] dw,
		input logic [3:0] be, input logic [31:0] wd);
		int n;
		repeat (2) @(negedge clock);
		cfg_req = 1'b1;
		cfg_cmd = '{wr, fn, dw, be, wd};
		@(negedge clock);
		cfg_req = 1'b0;
		chk("busy", 33'h1, {32'h0, cfg_busy});
		n = 0;
		while (cfg_ack !== 1'b1 && n < 8) begin
			@(negedge clock);
			n++;
		end
		if (n == 8) chk("ack", 33'h1, 33'h0);
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		#100_000;
		err_total++;
		end_sim();
	end

	initial begin
		repeat (16) @(negedge clock);
		srst = 1'b0;
		for (int f = 0; f < 2; f++) begin
			acc(1'b0, f[0], 6'h28, 4'hf, 32'h0);
			chk("read", {1'b1, 32'hfe11_0000}, cfg_rsp);
		end
		$display("test reset values done");
		acc(1'b1, 1'b0, 6'h28, 4'h8, 32'h0);
		acc(1'b0, 1'b0, 6'h28, 4'hf, 32'h0);
		chk("read_f0", {1'b1, 32'h7e11_0000}, cfg_rsp);
		chk("word_f0", {17'h0, 16'h7e11}, {17'h0, cap_word_f0});
		chk("word_f1", {17'h0, 16'hfe11}, {17'h0, cap_word_f1});
		$display("test cold wake clear done");
		for (int f = 0; f < 2; f++) begin
			for (int i = 0; i < 4; i++) begin
				acc(1'b1, f[0], 6'h28, bes[i], wds[i]);
				acc(1'b0, f[0], 6'h28, 4'hf, 32'h0);
				chk("masked", {1'b1, exw[i], 16'h0}, cfg_rsp);
			end
		end
		$display("test write mask done");
		acc(1'b1, 1'b0, 6'h29, 4'hf, 32'h0);
		acc(1'b0, 1'b0, 6'h29, 4'hf, 32'h0);
		chk("miss", 33'h0, cfg_rsp);
		acc(1'b0, 1'b0, 6'h28, 4'hf, 32'h0);
		chk("after_miss", {1'b1, 32'hfe11_0000}, cfg_rsp);
		$display("test unmapped done");
		for (int s = 0; s < 4; s++) begin
			pstate_f0 = s[1:0];
			pstate_f1 = 2'h3 - s[1:0];
			repeat (3) @(negedge clock);
			chk("wake_ok", 33'h3, {31'h0, wake_ok});
			chk("state_ok", 33'h3, {31'h0, state_ok});
		end
		$display("test power states done");
		acc(1'b1, 1'b1, 6'h28, 4'h8, 32'h0);
		repeat (2) @(negedge clock);
		chk("cleared_f1", {17'h0, 16'h7e11}, {17'h0, cap_word_f1});
		srst = 1'b1;
		repeat (2) @(negedge clock);
		srst = 1'b0;
		@(negedge clock);
		chk("reset_f1", {17'h0, 16'hfe11}, {17'h0, cap_word_f1});
		$display("test mid reset done");
		end_sim();
	end
endmodule
